/* File: include/pfss_pkg.sv */
// Function
// R1: Switching clock loss in voltage check moves to deep sleep.
// R2: Switching clock loss when active: error state, count up, set flag.
// R3: Low-power clock loss: shutdown, internal power-on reset, reinitialise.
// R4: Low-power clock loss: both resets low, power-on-reset flag set.
// R5: Core supply under/overvoltage sets power-on-reset flag, enters shutdown.
// R6: Regulator undervoltage in first state: self test, fail bit, resets low.
// R7: Regulator undervoltage in voltage check: deep sleep, fail bit, resets low.
// R8: Regulator undervoltage in ramp: error state, fail bit, resets low.
// R9: Regulator undervoltage when active sets fail bit, enters error state.
// R10: Regulator fail bit clears only after status read and undervoltage gone.
// R11: Overtemperature in power-up: error, count up, reset held meanwhile.
// R12: Overtemperature when active: reset, error, count up, reset held meanwhile.
// R13: Auxiliary above 4.8 V selects auxiliary source, only when active.
// R14: Auxiliary below 4.6 V returns source to protected battery input.
// R15: Illegal state codes go to first state with regulators off.
// R16: System reset output rises only after successful power-up.
// R17: Peripheral reset is latched system reset, rising after watchdog seen.
// R18: Regulator fail is power status bit 6; bit 7 is buck fail.
// R19: Error counter saturates, cleared only by power-on reset.
// R20: All fault flags synchronised to the main clock before use.
package pfss_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned STEP_TIME_US = 10;
  localparam int unsigned STEP_CYCLES =
    (STEP_TIME_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int STEP_W = 12;
  localparam int ERR_CNT_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SYNC_STAGES_W = 9;
  localparam logic [ADDR_W-1:0] ADDR_SYSTEM_STATUS_REGISTER = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_POWER_STATUS_REGISTER = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h0c;
  localparam int SYS_POR_BIT = 0;
  localparam int SYS_SWCLK_BIT = 1;
  localparam int PWR_REGFAIL_BIT = 6;
  localparam int PWR_BUCKFAIL_BIT = 7;
  localparam int STATE_LSB = 0;
  localparam int STATE_W = 4;
  localparam int CNT_LSB = 8;
  localparam int SRC_BIT = 16;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int F_SWCLK = 0;
  localparam int F_LPCLK = 1;
  localparam int F_CORE = 2;
  localparam int F_REGUV = 3;
  localparam int F_REGOT = 4;
  localparam int F_AUXHI = 5;
  localparam int F_AUXLO = 6;
  localparam int F_WDOG = 7;
  localparam int F_BUCK = 8;
  typedef enum logic [STATE_W-1:0] {
    PFSS_INIT,
    PFSS_SELF_TEST,
    PFSS_VOLT_CHECK,
    PFSS_RAMP,
    PFSS_ACTIVE,
    PFSS_ERROR,
    PFSS_DEEP_SLEEP,
    PFSS_SHUTDOWN
  } pfss_state_t;
endpackage : pfss_pkg

/* File: design/pfss_sync.sv */
`timescale 1ns/1ps
module pfss_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in; // R20
      sync_out <= meta_r; // R20
    end
  end
endmodule : pfss_sync

/* File: design/pfss_top.sv */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pfss_top #(
  parameter int unsigned STEP_CYCLES = pfss_pkg::STEP_CYCLES,
  parameter int ERR_CNT_W = pfss_pkg::ERR_CNT_W
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pfss_pkg::ADDR_W-1:0] PADDR,
  input wire logic [pfss_pkg::DATA_W-1:0] PWDATA,
  output logic [pfss_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SWITCHING_CLOCK_LOSS,
  input wire logic LOW_POWER_CLOCK_LOSS,
  input wire logic CORE_LOGIC_SUPPLY_FAULT,
  input wire logic REGULATOR_UNDERVOLTAGE,
  input wire logic REGULATOR_OVERTEMP,
  input wire logic AUX_SUPPLY_ABOVE_HIGH,
  input wire logic AUX_SUPPLY_BELOW_LOW,
  input wire logic WATCHDOG_TRIGGER_INPUT,
  input wire logic MAIN_BUCK_FAIL,
  output logic SYSTEM_RESET_OUT_N,
  output logic PERIPHERAL_RESET_OUT_N,
  output logic REGULATOR_ENABLE,
  output logic AUX_SOURCE_SELECT
);
  localparam logic [pfss_pkg::STEP_W-1:0] STEP_LAST =
    pfss_pkg::STEP_W'(STEP_CYCLES - 1);

  logic [pfss_pkg::SYNC_STAGES_W-1:0] flags_raw;
  logic [pfss_pkg::SYNC_STAGES_W-1:0] flags;
  logic swclk, lpclk, core, reg_uv, reg_ot, aux_hi, aux_lo, buck, crit;
  logic wd_d_r, wd_edge;

  pfss_pkg::pfss_state_t state_r, state_nxt;
  logic [pfss_pkg::STEP_W-1:0] step_r, step_nxt;
  logic [ERR_CNT_W-1:0] err_cnt_r, err_cnt_nxt;
  logic por_r, por_nxt, swf_r, swf_nxt, regf_r, regf_nxt;
  logic seen_r, seen_nxt, src_r, src_nxt;
  logic system_reset_out_n_nxt, peripheral_reset_out_n_nxt, regen_nxt;

  logic [pfss_pkg::DATA_W-1:0] rdata_nxt, rd;
  logic pready_nxt, slverr_nxt, access, apb_wr, pwr_read;
  logic sleep_cmd_r, sleep_cmd_nxt, wake_cmd_r, wake_cmd_nxt;
  logic clr_por, clr_swf, step_done;

  function automatic logic [ERR_CNT_W-1:0] sat_inc(
    input logic [ERR_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  assign flags_raw[pfss_pkg::F_SWCLK] = SWITCHING_CLOCK_LOSS;
  assign flags_raw[pfss_pkg::F_LPCLK] = LOW_POWER_CLOCK_LOSS;
  assign flags_raw[pfss_pkg::F_CORE] = CORE_LOGIC_SUPPLY_FAULT;
  assign flags_raw[pfss_pkg::F_REGUV] = REGULATOR_UNDERVOLTAGE;
  assign flags_raw[pfss_pkg::F_REGOT] = REGULATOR_OVERTEMP;
  assign flags_raw[pfss_pkg::F_AUXHI] = AUX_SUPPLY_ABOVE_HIGH;
  assign flags_raw[pfss_pkg::F_AUXLO] = AUX_SUPPLY_BELOW_LOW;
  assign flags_raw[pfss_pkg::F_WDOG] = WATCHDOG_TRIGGER_INPUT;
  assign flags_raw[pfss_pkg::F_BUCK] = MAIN_BUCK_FAIL;

  pfss_sync #(
    .W(pfss_pkg::SYNC_STAGES_W)
  ) u_sync (
    .clk(CLOCK),
    .rst(RST),
    .async_in(flags_raw),
    .sync_out(flags)
  );

  assign swclk = flags[pfss_pkg::F_SWCLK];
  assign lpclk = flags[pfss_pkg::F_LPCLK];
  assign core = flags[pfss_pkg::F_CORE];
  assign reg_uv = flags[pfss_pkg::F_REGUV];
  assign reg_ot = flags[pfss_pkg::F_REGOT];
  assign aux_hi = flags[pfss_pkg::F_AUXHI];
  assign aux_lo = flags[pfss_pkg::F_AUXLO];
  assign buck = flags[pfss_pkg::F_BUCK];
  assign crit = lpclk | core;
  assign wd_edge = flags[pfss_pkg::F_WDOG] & ~wd_d_r;

  // APB slave, one wait state
  assign access = PSEL & PENABLE & PREADY;
  assign apb_wr = access & PWRITE;
  assign pwr_read = access & ~PWRITE & (PADDR == pfss_pkg::ADDR_POWER_STATUS_REGISTER);
  assign clr_por = apb_wr & (PADDR == pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER)
                   & PWDATA[pfss_pkg::SYS_POR_BIT];
  assign clr_swf = apb_wr & (PADDR == pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER)
                   & PWDATA[pfss_pkg::SYS_SWCLK_BIT];

  always_comb
  begin
    rd = '0;
    pready_nxt = PSEL & PENABLE & ~PREADY;
    rdata_nxt = PRDATA;
    slverr_nxt = PSLVERR;
    sleep_cmd_nxt = apb_wr & (PADDR == pfss_pkg::ADDR_CTRL)
                    & PWDATA[pfss_pkg::CTRL_SLEEP_BIT];
    wake_cmd_nxt = apb_wr & (PADDR == pfss_pkg::ADDR_CTRL)
                   & PWDATA[pfss_pkg::CTRL_WAKE_BIT];
    slverr_nxt = 1'b0;
    unique case (PADDR)
      pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER:
      begin
        rd[pfss_pkg::SYS_POR_BIT] = por_r;
        rd[pfss_pkg::SYS_SWCLK_BIT] = swf_r;
      end
      pfss_pkg::ADDR_POWER_STATUS_REGISTER:
      begin
        rd[pfss_pkg::PWR_REGFAIL_BIT] = regf_r; // R18
        rd[pfss_pkg::PWR_BUCKFAIL_BIT] = buck; // R18
      end
      pfss_pkg::ADDR_STATE:
      begin
        rd[pfss_pkg::STATE_LSB +: pfss_pkg::STATE_W] = state_r;
        rd[pfss_pkg::CNT_LSB +: ERR_CNT_W] = err_cnt_r;
        rd[pfss_pkg::SRC_BIT] = src_r;
      end
      pfss_pkg::ADDR_CTRL:
      begin
        rd = '0;
      end
      default:
      begin
        slverr_nxt = 1'b1;
      end
    endcase
    if (pready_nxt)
    begin
      rdata_nxt = PWRITE ? '0 : rd;
    end
    else
    begin
      slverr_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
      sleep_cmd_r <= 1'b0;
      wake_cmd_r <= 1'b0;
    end
    else
    begin
      PREADY <= pready_nxt;
      PRDATA <= rdata_nxt;
      PSLVERR <= slverr_nxt;
      sleep_cmd_r <= sleep_cmd_nxt;
      wake_cmd_r <= wake_cmd_nxt;
    end
  end

  // Power state machine and status flags
  always_comb
  begin
    state_nxt = state_r;
    err_cnt_nxt = err_cnt_r;
    por_nxt = por_r & ~clr_por;
    swf_nxt = swf_r & ~clr_swf;
    regf_nxt = regf_r;
    seen_nxt = seen_r | (pwr_read & regf_r);
    src_nxt = src_r;
    step_done = (step_r >= STEP_LAST);
    step_nxt = step_done ? step_r : step_r + 1'b1;
    if (regf_r & seen_r & ~reg_uv)
    begin
      regf_nxt = 1'b0; // R10
      seen_nxt = 1'b0;
    end
    unique case (state_r)
      pfss_pkg::PFSS_INIT:
      begin
        if (reg_ot)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R11
          err_cnt_nxt = sat_inc(err_cnt_r); // R11 R19
        end
        else if (reg_uv)
        begin
          state_nxt = pfss_pkg::PFSS_SELF_TEST; // R6
          regf_nxt = 1'b1; // R6
        end
        else if (step_done)
          state_nxt = pfss_pkg::PFSS_SELF_TEST;
      end
      pfss_pkg::PFSS_SELF_TEST:
      begin
        if (reg_ot)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R11
          err_cnt_nxt = sat_inc(err_cnt_r); // R11
        end
        else if (step_done)
          state_nxt = pfss_pkg::PFSS_VOLT_CHECK;
      end
      pfss_pkg::PFSS_VOLT_CHECK:
      begin
        if (reg_ot)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R11
          err_cnt_nxt = sat_inc(err_cnt_r); // R11
        end
        else if (swclk)
          state_nxt = pfss_pkg::PFSS_DEEP_SLEEP; // R1
        else if (reg_uv)
        begin
          state_nxt = pfss_pkg::PFSS_DEEP_SLEEP; // R7
          regf_nxt = 1'b1; // R7
        end
        else if (step_done)
          state_nxt = pfss_pkg::PFSS_RAMP;
      end
      pfss_pkg::PFSS_RAMP:
      begin
        if (reg_ot)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R11
          err_cnt_nxt = sat_inc(err_cnt_r); // R11
        end
        else if (reg_uv)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R8
          regf_nxt = 1'b1; // R8
        end
        else if (step_done)
          state_nxt = pfss_pkg::PFSS_ACTIVE; // R16
      end
      pfss_pkg::PFSS_ACTIVE:
      begin
        if (reg_ot)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R12
          err_cnt_nxt = sat_inc(err_cnt_r); // R12
        end
        else if (swclk)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R2
          err_cnt_nxt = sat_inc(err_cnt_r); // R2
          swf_nxt = 1'b1; // R2
        end
        else if (reg_uv)
        begin
          state_nxt = pfss_pkg::PFSS_ERROR; // R9
          regf_nxt = 1'b1; // R9
        end
        else if (sleep_cmd_r)
          state_nxt = pfss_pkg::PFSS_DEEP_SLEEP;
      end
      pfss_pkg::PFSS_ERROR:
      begin
        // Held here while overtemperature lasts
        if (~reg_ot & ~reg_uv & ~swclk & step_done) // R11 R12
          state_nxt = pfss_pkg::PFSS_INIT;
      end
      pfss_pkg::PFSS_DEEP_SLEEP:
      begin
        if (wake_cmd_r)
          state_nxt = pfss_pkg::PFSS_INIT;
      end
      pfss_pkg::PFSS_SHUTDOWN:
      begin
        // Internal power-on reset of the error counter, clock and regulator fail flags and source select, not the reset flag
        err_cnt_nxt = '0; // R3 R19
        swf_nxt = 1'b0; // R3
        regf_nxt = 1'b0; // R3
        seen_nxt = 1'b0;
        src_nxt = 1'b0;
        if (~crit)
          state_nxt = pfss_pkg::PFSS_INIT;
      end
      default:
      begin
        state_nxt = pfss_pkg::PFSS_INIT; // R15
      end
    endcase
    if (aux_lo)
      src_nxt = 1'b0; // R14
    else if (aux_hi & (state_r == pfss_pkg::PFSS_ACTIVE))
      src_nxt = 1'b1; // R13
    if (crit)
    begin
      state_nxt = pfss_pkg::PFSS_SHUTDOWN; // R3 R5
      por_nxt = 1'b1; // R4 R5
    end
    if (state_nxt != state_r)
      step_nxt = '0;
    system_reset_out_n_nxt = (state_nxt == pfss_pkg::PFSS_ACTIVE); // R16 R4 R6 R7 R8 R12
    peripheral_reset_out_n_nxt = system_reset_out_n_nxt & (PERIPHERAL_RESET_OUT_N | wd_edge); // R17
    regen_nxt = (state_nxt == pfss_pkg::PFSS_RAMP)
                | (state_nxt == pfss_pkg::PFSS_ACTIVE); // R15
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_r <= pfss_pkg::PFSS_INIT;
      step_r <= '0;
      err_cnt_r <= '0;
      por_r <= 1'b1;
      swf_r <= 1'b0;
      regf_r <= 1'b0;
      seen_r <= 1'b0;
      src_r <= 1'b0;
      wd_d_r <= 1'b0;
      SYSTEM_RESET_OUT_N <= 1'b0;
      PERIPHERAL_RESET_OUT_N <= 1'b0;
      REGULATOR_ENABLE <= 1'b0;
      AUX_SOURCE_SELECT <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      err_cnt_r <= err_cnt_nxt;
      por_r <= por_nxt;
      swf_r <= swf_nxt;
      regf_r <= regf_nxt;
      seen_r <= seen_nxt;
      src_r <= src_nxt;
      wd_d_r <= flags[pfss_pkg::F_WDOG];
      SYSTEM_RESET_OUT_N <= system_reset_out_n_nxt;
      PERIPHERAL_RESET_OUT_N <= peripheral_reset_out_n_nxt;
      REGULATOR_ENABLE <= regen_nxt;
      AUX_SOURCE_SELECT <= src_nxt;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_calm;
    ~crit & ~reg_ot;
  endsequence
  sequence s_resets_low;
    ~SYSTEM_RESET_OUT_N & ~PERIPHERAL_RESET_OUT_N;
  endsequence

  a_voltage_check_state_swclk_sleep: assert property ( // R1
    s_calm and (state_r == pfss_pkg::PFSS_VOLT_CHECK) and swclk
    |=> state_r == pfss_pkg::PFSS_DEEP_SLEEP)
    else $error("switching clock loss in check not sleeping");
  a_active_swclk_error: assert property ( // R2
    s_calm and (state_r == pfss_pkg::PFSS_ACTIVE) and swclk
    |=> state_r == pfss_pkg::PFSS_ERROR && swf_r
        && err_cnt_r == sat_inc($past(err_cnt_r)))
    else $error("switching clock loss in active mishandled");
  a_lpclk_shutdown: assert property ( // R3
    lpclk |=> state_r == pfss_pkg::PFSS_SHUTDOWN ##1 err_cnt_r == '0)
    else $error("low-power clock loss not shutting down");
  a_lpclk_resets_por: assert property ( // R4
    lpclk |=> s_resets_low and por_r)
    else $error("low-power clock loss resets or flag wrong");
  a_core_fault_por: assert property ( // R5
    core |=> por_r && state_r == pfss_pkg::PFSS_SHUTDOWN)
    else $error("core supply fault not handled");
  a_init_uv_selftest: assert property ( // R6
    s_calm and (state_r == pfss_pkg::PFSS_INIT) and reg_uv
    |=> state_r == pfss_pkg::PFSS_SELF_TEST && regf_r ##0 s_resets_low)
    else $error("regulator undervoltage in init mishandled");
  a_check_uv_sleep: assert property ( // R7
    s_calm and (state_r == pfss_pkg::PFSS_VOLT_CHECK) and reg_uv and ~swclk
    |=> state_r == pfss_pkg::PFSS_DEEP_SLEEP && regf_r ##0 s_resets_low)
    else $error("regulator undervoltage in check mishandled");
  a_ramp_uv_error: assert property ( // R8
    s_calm and (state_r == pfss_pkg::PFSS_RAMP) and reg_uv
    |=> state_r == pfss_pkg::PFSS_ERROR && regf_r ##0 s_resets_low)
    else $error("regulator undervoltage in ramp mishandled");
  a_active_uv_error: assert property ( // R9
    s_calm and (state_r == pfss_pkg::PFSS_ACTIVE) and reg_uv and ~swclk
    |=> state_r == pfss_pkg::PFSS_ERROR && regf_r)
    else $error("regulator undervoltage in active mishandled");
  a_regfail_sticky: assert property ( // R10
    regf_r && (reg_uv || !seen_r) && state_r != pfss_pkg::PFSS_SHUTDOWN
    |=> regf_r)
    else $error("regulator fail cleared too early");
  a_ot_holds_reset: assert property ( // R11
    reg_ot && !crit && state_r != pfss_pkg::PFSS_DEEP_SLEEP
    && state_r != pfss_pkg::PFSS_SHUTDOWN |=> !SYSTEM_RESET_OUT_N
      && state_r == pfss_pkg::PFSS_ERROR)
    else $error("overtemperature did not hold reset");
  a_active_ot_count: assert property ( // R12
    reg_ot && !crit && state_r == pfss_pkg::PFSS_ACTIVE
    |=> err_cnt_r == sat_inc($past(err_cnt_r)) && !SYSTEM_RESET_OUT_N)
    else $error("overtemperature in active not counted");
  a_aux_switch: assert property ( // R13
    aux_hi && !aux_lo && !crit && state_r == pfss_pkg::PFSS_ACTIVE
    |=> AUX_SOURCE_SELECT)
    else $error("auxiliary source not selected");
  a_aux_return: assert property ( // R14
    aux_lo |=> !AUX_SOURCE_SELECT)
    else $error("source not returned to battery input");
  a_init_regs_off: assert property ( // R15
    state_r == pfss_pkg::PFSS_INIT |-> !REGULATOR_ENABLE)
    else $error("regulators on in first state");
  a_system_reset_out_n_after_powerup: assert property ( // R16
    $rose(SYSTEM_RESET_OUT_N) |-> $past(state_r) == pfss_pkg::PFSS_RAMP)
    else $error("system reset rose without power-up");
  a_peripheral_reset_out_n_after_wdog: assert property ( // R17
    $rose(PERIPHERAL_RESET_OUT_N) |-> SYSTEM_RESET_OUT_N && $past(wd_edge))
    else $error("peripheral reset rose without watchdog");
endmodule : pfss_top

/* File: test/pfss_host_model.sv */
`timescale 1ns/1ps
module pfss_host_model (
  input wire logic clk,
  input wire logic wd_en,
  input wire logic sys_rst_n,
  output logic wd_out
);
  logic [3:0] cnt_r = 4'h0;
  initial wd_out = 1'b0;
  // Host held in reset keeps its watchdog pin low
  always @(posedge clk)
  begin
    if (!sys_rst_n || !wd_en)
    begin
      cnt_r <= 4'h0;
      wd_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      wd_out <= cnt_r[3];
    end
  end
endmodule : pfss_host_model

/* File: test/pfss_top_test.sv */
`timescale 1ns/1ps
module pfss_top_test;
  localparam int unsigned STEP = 16;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [pfss_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] flt = 9'h000;
  logic wd_en = 1'b0;
  logic wd;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic sys_n;
  logic per_n;
  logic reg_en;
  logic aux;
  int fail_count = 0;
  int n_compared = 0;

  always #12.5 clock = ~clock;

  pfss_top #(.STEP_CYCLES(STEP), .ERR_CNT_W(2)) dut_u (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr),
    .SWITCHING_CLOCK_LOSS(flt[pfss_pkg::F_SWCLK]),
    .LOW_POWER_CLOCK_LOSS(flt[pfss_pkg::F_LPCLK]),
    .CORE_LOGIC_SUPPLY_FAULT(flt[pfss_pkg::F_CORE]),
    .REGULATOR_UNDERVOLTAGE(flt[pfss_pkg::F_REGUV]),
    .REGULATOR_OVERTEMP(flt[pfss_pkg::F_REGOT]),
    .AUX_SUPPLY_ABOVE_HIGH(flt[pfss_pkg::F_AUXHI]),
    .AUX_SUPPLY_BELOW_LOW(flt[pfss_pkg::F_AUXLO]),
    .WATCHDOG_TRIGGER_INPUT(wd), .MAIN_BUCK_FAIL(flt[pfss_pkg::F_BUCK]),
    .SYSTEM_RESET_OUT_N(sys_n), .PERIPHERAL_RESET_OUT_N(per_n),
    .REGULATOR_ENABLE(reg_en), .AUX_SOURCE_SELECT(aux)
  );

  pfss_host_model host_u (
    .clk(clock), .wd_en(wd_en), .sys_rst_n(sys_n), .wd_out(wd)
  );

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_state;
    apb(1'b0, pfss_pkg::ADDR_STATE, 32'h0);
  endtask : rd_state

  task automatic do_reset;
    rst <= 1'b1;
    flt <= 9'h000;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset

  task automatic go_active;
    int n;
    n = 0;
    while (sys_n !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    chk("sys_n up", 32'h1, 32'(sys_n));
  endtask : go_active

  // Raise one fault, then expect resets low and the given state
  task automatic hit(input int f, input logic [3:0] es);
    flt[f] <= 1'b1;
    repeat (5) @(posedge clock);
    chk("sys_n", 32'h0, 32'(sys_n));
    chk("per_n", 32'h0, 32'(per_n));
    rd_state;
    chk("state", 32'(es), 32'(rd[3:0]));
  endtask : hit

  task automatic t_reset;
    repeat (3) @(posedge clock);
    chk("rst sys_n", 32'h0, 32'(sys_n));
    chk("rst per_n", 32'h0, 32'(per_n));
    chk("rst reg_en", 32'h0, 32'(reg_en));
    chk("rst aux", 32'h0, 32'(aux));
    do_reset;
    rd_state;
    chk("init", 32'(pfss_pkg::PFSS_INIT), 32'(rd[3:0]));
    apb(1'b0, pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h0);
    chk("por", 32'h1, 32'(rd[pfss_pkg::SYS_POR_BIT]));
    apb(1'b1, pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h1);
    apb(1'b0, pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h0);
    chk("por clr", 32'h0, 32'(rd[pfss_pkg::SYS_POR_BIT]));
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("bad data", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_power;
    int n;
    n = 0;
    wd_en <= 1'b0;
    do_reset;
    repeat (40) @(posedge clock);
    chk("sys_n early", 32'h0, 32'(sys_n));
    go_active;
    rd_state;
    chk("active", 32'(pfss_pkg::PFSS_ACTIVE), 32'(rd[3:0]));
    chk("reg_en on", 32'h1, 32'(reg_en));
    repeat (30) @(posedge clock);
    chk("per_n no wd", 32'h0, 32'(per_n));
    wd_en <= 1'b1;
    while (per_n !== 1'b1 && n < 40)
    begin
      @(posedge clock);
      n++;
    end
    chk("per_n wd", 32'h1, 32'(per_n));
    apb(1'b1, pfss_pkg::ADDR_CTRL, 32'h1);
    rd_state;
    chk("sleep", 32'(pfss_pkg::PFSS_DEEP_SLEEP), 32'(rd[3:0]));
    apb(1'b1, pfss_pkg::ADDR_CTRL, 32'h2);
    rd_state;
    chk("wake", 32'(pfss_pkg::PFSS_INIT), 32'(rd[3:0]));
    $display("test power done");
  endtask : t_power

  task automatic t_aux;
    do_reset;
    flt[pfss_pkg::F_AUXHI] <= 1'b1;
    repeat (8) @(posedge clock);
    chk("aux boot", 32'h0, 32'(aux));
    flt[pfss_pkg::F_AUXHI] <= 1'b0;
    go_active;
    flt[pfss_pkg::F_AUXHI] <= 1'b1;
    repeat (5) @(posedge clock);
    chk("aux hi", 32'h1, 32'(aux));
    flt[pfss_pkg::F_AUXHI] <= 1'b0;
    repeat (5) @(posedge clock);
    chk("aux hold", 32'h1, 32'(aux));
    flt[pfss_pkg::F_AUXLO] <= 1'b1;
    repeat (5) @(posedge clock);
    chk("aux lo", 32'h0, 32'(aux));
    $display("test aux done");
  endtask : t_aux

  task automatic t_swclk;
    do_reset;
    go_active;
    flt[pfss_pkg::F_SWCLK] <= 1'b1;
    repeat (3) @(posedge clock);
    chk("sync lag", 32'h1, 32'(sys_n));
    @(posedge clock);
    chk("swclk sys_n", 32'h0, 32'(sys_n));
    rd_state;
    chk("swclk st", 32'(pfss_pkg::PFSS_ERROR), 32'(rd[3:0]));
    chk("swclk cnt", 32'h1, 32'(rd[15:8]));
    apb(1'b0, pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h0);
    chk("swclk bit", 32'h1, 32'(rd[pfss_pkg::SYS_SWCLK_BIT]));
    $display("test swclk done");
  endtask : t_swclk

  task automatic t_uv;
    do_reset;
    go_active;
    hit(pfss_pkg::F_REGUV, pfss_pkg::PFSS_ERROR);
    flt <= 9'h001 << pfss_pkg::F_BUCK;
    repeat (8) @(posedge clock);
    apb(1'b0, pfss_pkg::ADDR_POWER_STATUS_REGISTER, 32'h0);
    chk("fail held", 32'h1, 32'(rd[pfss_pkg::PWR_REGFAIL_BIT]));
    chk("buck", 32'h1, 32'(rd[pfss_pkg::PWR_BUCKFAIL_BIT]));
    apb(1'b0, pfss_pkg::ADDR_POWER_STATUS_REGISTER, 32'h0);
    chk("fail clr", 32'h0, 32'(rd[pfss_pkg::PWR_REGFAIL_BIT]));
    $display("test uv done");
  endtask : t_uv

  task automatic t_ot;
    do_reset;
    go_active;
    hit(pfss_pkg::F_REGOT, pfss_pkg::PFSS_ERROR);
    chk("ot cnt", 32'h1, 32'(rd[15:8]));
    repeat (3 * STEP) @(posedge clock);
    chk("ot hold", 32'h0, 32'(sys_n));
    rd_state;
    chk("ot st", 32'(pfss_pkg::PFSS_ERROR), 32'(rd[3:0]));
    $display("test ot done");
  endtask : t_ot

  task automatic t_boot;
    logic [3:0] at [5] = '{pfss_pkg::PFSS_VOLT_CHECK, pfss_pkg::PFSS_INIT,
      pfss_pkg::PFSS_VOLT_CHECK, pfss_pkg::PFSS_RAMP,
      pfss_pkg::PFSS_SELF_TEST};
    int fl [5] = '{pfss_pkg::F_SWCLK, pfss_pkg::F_REGUV, pfss_pkg::F_REGUV,
      pfss_pkg::F_REGUV, pfss_pkg::F_REGOT};
    logic [3:0] ex [5] = '{pfss_pkg::PFSS_DEEP_SLEEP,
      pfss_pkg::PFSS_SELF_TEST, pfss_pkg::PFSS_DEEP_SLEEP,
      pfss_pkg::PFSS_ERROR, pfss_pkg::PFSS_ERROR};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      do_reset;
      n = 0;
      do
      begin
        rd_state;
        n++;
      end
      while (rd[3:0] !== at[i] && n < 30);
      hit(fl[i], ex[i]);
      if (fl[i] == pfss_pkg::F_REGOT)
        chk("boot cnt", 32'h1, 32'(rd[15:8]));
      else if (fl[i] == pfss_pkg::F_REGUV)
      begin
        apb(1'b0, pfss_pkg::ADDR_POWER_STATUS_REGISTER, 32'h0);
        chk("boot fail", 32'h1, 32'(rd[6]));
      end
    end
    $display("test boot done");
  endtask : t_boot

  task automatic t_shut;
    int f;
    for (int i = 0; i < 2; i++)
    begin
      f = (i == 0) ? pfss_pkg::F_LPCLK : pfss_pkg::F_CORE;
      do_reset;
      go_active;
      apb(1'b1, pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h1);
      repeat (20) @(posedge clock);
      chk("shut per_n up", 32'h1, 32'(per_n));
      hit(f, pfss_pkg::PFSS_SHUTDOWN);
      chk("shut reg_en", 32'h0, 32'(reg_en));
      apb(1'b0, pfss_pkg::ADDR_SYSTEM_STATUS_REGISTER, 32'h0);
      chk("shut por", 32'h1, 32'(rd[pfss_pkg::SYS_POR_BIT]));
    end
    $display("test shutdown done");
  endtask : t_shut

  task automatic t_sat;
    do_reset;
    repeat (5)
    begin
      go_active;
      flt[pfss_pkg::F_SWCLK] <= 1'b1;
      repeat (5) @(posedge clock);
      flt[pfss_pkg::F_SWCLK] <= 1'b0;
    end
    rd_state;
    chk("sat cnt", 32'h3, 32'(rd[15:8]));
    flt[pfss_pkg::F_LPCLK] <= 1'b1;
    repeat (5) @(posedge clock);
    flt[pfss_pkg::F_LPCLK] <= 1'b0;
    repeat (3) @(posedge clock);
    rd_state;
    chk("cnt clr", 32'h0, 32'(rd[15:8]));
    $display("test saturate done");
  endtask : t_sat

  initial
  begin
    t_reset;
    t_power;
    t_aux;
    t_swclk;
    t_uv;
    t_ot;
    t_boot;
    t_shut;
    t_sat;
    end_of_test;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_of_test;
  end
endmodule : pfss_top_test
